// ---- hdl/eru_ext_regs.sv ----
`timescale 1ns/1ps
// Operation
// - Unlock register at 29h, reset zero
// - Group writes only when low bits 101
// - Group reads need bit7 high, bit3 low
// - Unlock bits 6:4 set to 101 select test mode
// - Config bits 3:0 cleared, read/write
// - Memory-mode straps captured into bits 7:5
// - Strap bit readable through 3C2h bit 4
// - Two bus straps select host interface
// - Bit 2 freezes clock select loading
// - Bit 1 locks screen-control fields
// - Bit 0 locks character clock width
// - Locked bits read back as written
// - Bit 3 selects EGA emulation timing
// - Scratch at 2Bh, kept through reset
// - Scratch becomes line-pulse count adjustment
// - Half-line start used only interlaced
// - Interlace bits 7:5 reset, 4:0 kept
// - Bit 7 enables CRT interrupts
// - Bit 6 doubles scan when polarity positive
// - Bit 5 selects interlaced timing
module eru_ext_regs
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // CRT controller index/data port
    input  wire logic [7:0] crtc_index,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    // Straps
    input  wire logic [2:0] mem_mode_strap,
    input  wire logic       bus_arch_strap_hi,
    input  wire logic       bus_arch_strap_lo,
    // Miscellaneous output register context
    input  wire logic       ega_compat,
    input  wire logic [1:0] misc_out_sel,
    input  wire logic       vsync_pos,
    output logic            misc_in_strap,
    // Lock-aware shadowing of other units' written values
    input  wire logic       clk_sel_wr,
    input  wire logic [1:0] clk_sel_wdata,
    output logic      [1:0] clk_sel_eff_q,
    output logic            clk_synth_load,
    input  wire logic       gc05_wr,
    input  wire logic [1:0] gc05_wdata,
    output logic      [1:0] gc05_eff_q,
    input  wire logic       sq01_wr,
    input  wire logic [4:0] sq01_wdata,
    output logic      [4:0] sq01_eff_q,
    input  wire logic       sq03_wr,
    input  wire logic [5:0] sq03_wdata,
    output logic      [5:0] sq03_eff_q,
    // Misc control three bit 6 state
    input  wire logic       misc3_lp_en,
    // Timing controls to CRTC
    output logic            ega_emu,
    output logic            lp_adj_valid,
    output logic      [7:0] lp_adj,
    output logic            interlace_en,
    output logic      [7:0] half_start,
    output logic      [4:0] half_end,
    output logic            dbl_scan,
    output logic            crtc_irq_en,
    output logic            test_mode,
    output eru_pkg::eru_host_e host_mode
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0] unlock_q;
    logic [3:0] cfg_lo_q;
    logic [7:0] scratch_q;
    logic [7:0] half_st_q;
    logic [2:0] il_hi_q;
    logic [4:0] il_lo_q;
    logic [2:0] mem_mode_q;
    logic       bus_hi_q;
    logic       strap_bit;

    eru_strap_latch u_straps
    (
        .core_clk          (core_clk),
        .rst               (rst),
        .ce                (ce),
        .mem_mode_strap    (mem_mode_strap),
        .bus_arch_strap_hi (bus_arch_strap_hi),
        .bus_arch_strap_lo (bus_arch_strap_lo),
        .mem_mode_q        (mem_mode_q),
        .bus_hi_q          (bus_hi_q),
        .host_mode_q       (host_mode)
    );

    eru_strap_select u_sel
    (
        .mem_mode_q   (mem_mode_q),
        .bus_hi_q     (bus_hi_q),
        .misc_out_sel (misc_out_sel),
        .strap_bit    (strap_bit)
    );

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire hit_unlock = (crtc_index == eru_pkg::IDX_UNLOCK);
    wire in_grp     = (crtc_index >= eru_pkg::IDX_GRP_FIRST) &&
                      (crtc_index <= eru_pkg::IDX_GRP_LAST);
    wire wr_open    = (unlock_q[2:0] == eru_pkg::WR_KEY);
    wire rd_open    = unlock_q[eru_pkg::RD_EN_HI_BIT] &&
                      !unlock_q[eru_pkg::RD_EN_LO_BIT];
    wire grp_wr     = ce && reg_wr && wr_open;
    wire wr_cfg     = grp_wr && (crtc_index == eru_pkg::IDX_CFG_SW);
    wire wr_scr     = grp_wr && (crtc_index == eru_pkg::IDX_SCRATCH);
    wire wr_hst     = grp_wr && (crtc_index == eru_pkg::IDX_HALF_ST);
    wire wr_hend    = grp_wr && (crtc_index == eru_pkg::IDX_HALF_END);
    wire lock_clk   = cfg_lo_q[eru_pkg::CFG_LOCK_CLK];
    wire lock_scr   = cfg_lo_q[eru_pkg::CFG_LOCK_SCR];
    wire lock_89    = cfg_lo_q[eru_pkg::CFG_LOCK_89];

    logic [7:0] grp_data;
    assign grp_data = (crtc_index == eru_pkg::IDX_CFG_SW)  ? {mem_mode_q, bus_hi_q, cfg_lo_q} :
                      (crtc_index == eru_pkg::IDX_SCRATCH) ? scratch_q :
                      (crtc_index == eru_pkg::IDX_HALF_ST) ? half_st_q :
                      (crtc_index == eru_pkg::IDX_HALF_END) ? {il_hi_q, il_lo_q} :
                                                             eru_pkg::READ_BLOCKED;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (ce)
        begin
            if (rst)
            begin
                unlock_q <= eru_pkg::UNLOCK_RST;
                cfg_lo_q <= eru_pkg::CFG_LO_RST;
                il_hi_q  <= eru_pkg::IL_HI_RST;
            end
            else
            begin
                if (reg_wr && hit_unlock)
                    unlock_q <= reg_wdata;
                if (wr_cfg)
                    cfg_lo_q <= reg_wdata[3:0];
                if (wr_hend)
                    il_hi_q <= reg_wdata[7:5];
            end
        end
    end

    // No reset on these: contents survive hardware reset
    always_ff @(posedge core_clk)
    begin
        if (ce && !rst)
        begin
            if (wr_scr)
                scratch_q <= reg_wdata;
            if (wr_hst)
                half_st_q <= reg_wdata;
            if (wr_hend)
                il_lo_q <= reg_wdata[4:0];
        end
    end

    // ------------------------------------------------------------------
    // Lock shadows: the written copy lives in the owning unit for reads;
    // here only the effective setting is held, updated when unlocked
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (ce)
        begin
            if (rst)
            begin
                clk_sel_eff_q <= 2'h0;
                gc05_eff_q    <= 2'h0;
                sq01_eff_q    <= 5'h00;
                sq03_eff_q    <= 6'h00;
            end
            else
            begin
                if (clk_sel_wr && !lock_clk)
                    clk_sel_eff_q <= clk_sel_wdata;
                if (gc05_wr && !lock_scr)
                    gc05_eff_q <= gc05_wdata;
                if (sq01_wr)
                begin
                    if (!lock_scr)
                        sq01_eff_q[4:1] <= sq01_wdata[4:1];
                    if (!lock_89)
                        sq01_eff_q[0] <= sq01_wdata[0];
                end
                if (sq03_wr && !lock_scr)
                    sq03_eff_q <= sq03_wdata;
            end
        end
    end

    assign clk_synth_load = ce && clk_sel_wr && !lock_clk && !rst;

    // ------------------------------------------------------------------
    // Read path and controls
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (ce)
        begin
            if (rst)
                reg_rdata <= 8'h00;
            else if (reg_rd && hit_unlock)
                reg_rdata <= unlock_q;
            else if (reg_rd && in_grp)
                reg_rdata <= rd_open ? grp_data : eru_pkg::READ_BLOCKED;
        end
    end

    assign reg_hit       = hit_unlock || in_grp;
    assign misc_in_strap = ega_compat && strap_bit;
    assign ega_emu       = cfg_lo_q[eru_pkg::CFG_EGA_EMU];
    assign lp_adj_valid  = misc3_lp_en;
    assign lp_adj        = scratch_q;
    assign interlace_en  = il_hi_q[eru_pkg::IL_INTERLACE - 5];
    assign half_start    = interlace_en ? half_st_q : 8'h00;
    assign half_end      = il_lo_q;
    assign dbl_scan      = il_hi_q[eru_pkg::IL_DBL_SCAN - 5] && vsync_pos;
    assign crtc_irq_en   = il_hi_q[eru_pkg::IL_IRQ_EN - 5];
    assign test_mode     = (unlock_q[6:4] == eru_pkg::TEST_KEY);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_unlock_rst;
        @(posedge core_clk) (rst && ce) |=> (unlock_q == 8'h00);
    endproperty
    a_unlock_rst: assert property (p_unlock_rst) else $error("unlock not cleared");

    property p_wr_block;
        @(posedge core_clk) disable iff (rst)
        (ce && reg_wr && !wr_open && crtc_index == eru_pkg::IDX_SCRATCH)
        |=> $stable(scratch_q);
    endproperty
    a_wr_block: assert property (p_wr_block) else $error("protected write landed");

    property p_rd_block;
        @(posedge core_clk) disable iff (rst)
        (ce && reg_rd && in_grp && !rd_open) |=> (reg_rdata == 8'h00);
    endproperty
    a_rd_block: assert property (p_rd_block) else $error("blocked read not zero");

    property p_cfg_rst;
        @(posedge core_clk) (rst && ce) |=> (cfg_lo_q == 4'h0 && il_hi_q == 3'h0);
    endproperty
    a_cfg_rst: assert property (p_cfg_rst) else $error("reset bits not cleared");

    property p_clk_lock;
        @(posedge core_clk) disable iff (rst)
        (ce && lock_clk) |=> $stable(clk_sel_eff_q);
    endproperty
    a_clk_lock: assert property (p_clk_lock) else $error("clock select moved");

    property p_scr_lock;
        @(posedge core_clk) disable iff (rst)
        (ce && lock_scr && $stable(cfg_lo_q)) |=> $stable(gc05_eff_q) && $stable(sq03_eff_q);
    endproperty
    a_scr_lock: assert property (p_scr_lock) else $error("screen lock broken");

    property p_89_lock;
        @(posedge core_clk) disable iff (rst)
        (ce && lock_89) |=> (sq01_eff_q[0] == $past(sq01_eff_q[0]));
    endproperty
    a_89_lock: assert property (p_89_lock) else $error("dot width moved");

    property p_scr_keep;
        @(posedge core_clk) (rst) |=> $stable(scratch_q);
    endproperty
    a_scr_keep: assert property (p_scr_keep) else $error("scratch lost at reset");

    property p_dbl;
        @(posedge core_clk) disable iff (rst)
        (wr_hend && reg_wdata[eru_pkg::IL_DBL_SCAN]) |=> (dbl_scan == vsync_pos);
    endproperty
    a_dbl: assert property (p_dbl) else $error("double scan wrong");

    property p_unlock_wr;
        @(posedge core_clk) disable iff (rst)
        (ce && reg_wr && hit_unlock) |=> (unlock_q == $past(reg_wdata));
    endproperty
    a_unlock_wr: assert property (p_unlock_wr) else $error("unlock write lost");

    property p_unlock_rd;
        @(posedge core_clk) disable iff (rst)
        (ce && reg_rd && hit_unlock) |=> (reg_rdata == $past(unlock_q));
    endproperty
    a_unlock_rd: assert property (p_unlock_rd) else $error("unlock read wrong");

    property p_wr_land;
        @(posedge core_clk) disable iff (rst)
        wr_scr |=> (scratch_q == $past(reg_wdata));
    endproperty
    a_wr_land: assert property (p_wr_land) else $error("open write lost");

    property p_rd_open;
        @(posedge core_clk) disable iff (rst)
        (ce && reg_rd && in_grp && rd_open) |=> (reg_rdata == $past(grp_data));
    endproperty
    a_rd_open: assert property (p_rd_open) else $error("open read wrong");

    property p_cfg_wr;
        @(posedge core_clk) disable iff (rst)
        wr_cfg |=> (cfg_lo_q == $past(reg_wdata[3:0]));
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("switch write lost");

    property p_strap_hold;
        @(posedge core_clk)
        (!rst) |=> ($stable(mem_mode_q) && $stable(host_mode));
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap moved");

    property p_clk_pass;
        @(posedge core_clk) disable iff (rst)
        (ce && clk_sel_wr && !lock_clk) |=> (clk_sel_eff_q == $past(clk_sel_wdata));
    endproperty
    a_clk_pass: assert property (p_clk_pass) else $error("clock select not taken");

    property p_dot_pass;
        @(posedge core_clk) disable iff (rst)
        (ce && sq01_wr && !lock_89) |=> (sq01_eff_q[0] == $past(sq01_wdata[0]));
    endproperty
    a_dot_pass: assert property (p_dot_pass) else $error("dot width not taken");

    property p_il_wr;
        @(posedge core_clk) disable iff (rst)
        wr_hend |=> ({il_hi_q, il_lo_q} == $past(reg_wdata));
    endproperty
    a_il_wr: assert property (p_il_wr) else $error("interlace write lost");
endmodule : eru_ext_regs

// ---- hdl/eru_pkg.sv ----
package eru_pkg;
    // ------------------------------------------------------------------
    // Register indices on the CRT controller data port
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_UNLOCK    = 8'h29;
    localparam logic [7:0] IDX_CFG_SW    = 8'h2a;
    localparam logic [7:0] IDX_SCRATCH   = 8'h2b;
    localparam logic [7:0] IDX_HALF_ST   = 8'h2c;
    localparam logic [7:0] IDX_HALF_END  = 8'h2d;
    localparam logic [7:0] IDX_GRP_FIRST = 8'h2a;
    localparam logic [7:0] IDX_GRP_LAST  = 8'h30;
    // ------------------------------------------------------------------
    // Field positions and access codes
    // ------------------------------------------------------------------
    localparam logic [2:0] WR_KEY        = 3'h5;
    localparam logic [2:0] TEST_KEY      = 3'h5;
    localparam int         RD_EN_HI_BIT  = 7;
    localparam int         RD_EN_LO_BIT  = 3;
    localparam int         CFG_EGA_EMU   = 3;
    localparam int         CFG_LOCK_CLK  = 2;
    localparam int         CFG_LOCK_SCR  = 1;
    localparam int         CFG_LOCK_89   = 0;
    localparam int         IL_IRQ_EN     = 7;
    localparam int         IL_DBL_SCAN   = 6;
    localparam int         IL_INTERLACE  = 5;
    localparam int         MISC3_LP_BIT  = 6;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] UNLOCK_RST    = 8'h00;
    localparam logic [3:0] CFG_LO_RST    = 4'h0;
    localparam logic [2:0] IL_HI_RST     = 3'h0;
    localparam logic [7:0] READ_BLOCKED  = 8'h00;
    // ------------------------------------------------------------------
    // Host interface encoding
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ERU_HOST_RSVD, ERU_HOST_ISA, ERU_HOST_LOCAL} eru_host_e;
endpackage : eru_pkg

// ---- hdl/eru_strap_latch.sv ----
`timescale 1ns/1ps
// Catches straps by clock while reset is held, so no async load of a pin
module eru_strap_latch
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic [2:0] mem_mode_strap,
    input  wire logic       bus_arch_strap_hi,
    input  wire logic       bus_arch_strap_lo,
    output logic      [2:0] mem_mode_q,
    output logic            bus_hi_q,
    output eru_pkg::eru_host_e host_mode_q
);
    eru_pkg::eru_host_e host_d;
    assign host_d = (bus_arch_strap_lo && !bus_arch_strap_hi) ? eru_pkg::ERU_HOST_ISA :
                    (bus_arch_strap_lo &&  bus_arch_strap_hi) ? eru_pkg::ERU_HOST_LOCAL :
                                                                eru_pkg::ERU_HOST_RSVD;
    always_ff @(posedge core_clk)
    begin
        if (ce && rst)
        begin
            mem_mode_q  <= mem_mode_strap;
            bus_hi_q    <= bus_arch_strap_hi;
            host_mode_q <= host_d;
        end
    end
endmodule : eru_strap_latch

// ---- hdl/eru_strap_select.sv ----
`timescale 1ns/1ps
module eru_strap_select
(
    input  wire logic [2:0] mem_mode_q,
    input  wire logic       bus_hi_q,
    input  wire logic [1:0] misc_out_sel,
    output logic            strap_bit
);
    assign strap_bit = (misc_out_sel == 2'h0) ? mem_mode_q[2] :
                       (misc_out_sel == 2'h1) ? mem_mode_q[1] :
                       (misc_out_sel == 2'h2) ? mem_mode_q[0] : bus_hi_q;
endmodule : eru_strap_select

// ---- dv/tb_ext_reg_unlock_and_interlace_ctrl.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
        begin \
            errors++; \
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
        end \
    end
module tb_ext_reg_unlock_and_interlace_ctrl;
    logic       core_clk          = 1'b0;
    logic       rst               = 1'b1;
    logic       ce                = 1'b1;
    logic [7:0] crtc_index        = 8'h00;
    logic       reg_wr            = 1'b0;
    logic       reg_rd            = 1'b0;
    logic [7:0] reg_wdata         = 8'h00;
    logic [2:0] mem_mode_strap    = 3'h5;
    logic       bus_arch_strap_hi = 1'b1;
    logic       bus_arch_strap_lo = 1'b1;
    logic       ega_compat        = 1'b0;
    logic [1:0] misc_out_sel      = 2'h0;
    logic       vsync_pos         = 1'b0;
    logic       clk_sel_wr        = 1'b0;
    logic [1:0] clk_sel_wdata     = 2'h0;
    logic       gc05_wr           = 1'b0;
    logic [1:0] gc05_wdata        = 2'h0;
    logic       sq01_wr           = 1'b0;
    logic [4:0] sq01_wdata        = 5'h00;
    logic       sq03_wr           = 1'b0;
    logic [5:0] sq03_wdata        = 6'h00;
    logic       misc3_lp_en       = 1'b0;
    logic [7:0] reg_rdata, lp_adj, half_start;
    logic       reg_hit, misc_in_strap, clk_synth_load, ega_emu, lp_adj_valid;
    logic       interlace_en, dbl_scan, crtc_irq_en, test_mode;
    logic [1:0] clk_sel_eff_q, gc05_eff_q;
    logic [4:0] sq01_eff_q, half_end;
    logic [5:0] sq03_eff_q;
    eru_pkg::eru_host_e host_mode;
    int         errors = 0, samples_checked = 0, cycles = 0;
    integer     seed = 32'hfc96590f;
    logic [31:0] rv;
    logic [7:0] sv, hs, ctl, cv;
    logic [5:0] d0, d1;
    logic [3:0] nib, lk;
    logic       hit_ex;

    always #4 core_clk = ~core_clk;

    eru_ext_regs i_dut (.*);

    // ------------------------------------------------------------------
    // Expectations and bus cycles
    // ------------------------------------------------------------------
    function automatic eru_pkg::eru_host_e exp_host(input logic hi, input logic lo);
        if (lo && !hi) return eru_pkg::ERU_HOST_ISA;
        if (lo && hi) return eru_pkg::ERU_HOST_LOCAL;
        return eru_pkg::ERU_HOST_RSVD;
    endfunction : exp_host

    // Strap half mirrors what the bench drove while reset was held
    function automatic logic [7:0] exp_cfg(input logic [3:0] n);
        return {mem_mode_strap, bus_arch_strap_hi, n};
    endfunction : exp_cfg

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(negedge core_clk);
        crtc_index = idx;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] ex, input string nm);
        @(negedge core_clk);
        crtc_index = idx;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        `CHK(nm, ex, reg_rdata)
    endtask : rdchk

    // All four foreign write events at once, so one pass shows every lock
    task automatic oth(input logic [5:0] d, input logic ld);
        @(negedge core_clk);
        clk_sel_wdata = d[1:0];
        gc05_wdata = d[1:0];
        sq01_wdata = d[4:0];
        sq03_wdata = d;
        {clk_sel_wr, gc05_wr, sq01_wr, sq03_wr} = 4'hf;
        #1;
        `CHK("synth load", ld, clk_synth_load)
        @(negedge core_clk);
        {clk_sel_wr, gc05_wr, sq01_wr, sq03_wr} = 4'h0;
    endtask : oth

    task automatic do_reset(input logic hi, input logic lo);
        @(negedge core_clk);
        rst = 1'b1;
        bus_arch_strap_hi = hi;
        bus_arch_strap_lo = lo;
        rv = $random(seed);
        mem_mode_strap = rv[2:0];
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
    endtask : do_reset

    task automatic tend(input string nm);
        $display("test %s done: %0d checks, %0d mismatches", nm, samples_checked, errors);
    endtask : tend

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        do_reset(1'b1, 1'b1);
        rdchk(eru_pkg::IDX_UNLOCK, eru_pkg::UNLOCK_RST, "unlock");
        rdchk(eru_pkg::IDX_CFG_SW, eru_pkg::READ_BLOCKED, "cfg blocked");
        `CHK("host", exp_host(1'b1, 1'b1), host_mode)
        `CHK("ilace hi", 3'h0, {crtc_irq_en, dbl_scan, interlace_en})
        // Index decode: just past both range ends, then random indices around the group
        for (int j = 0; j < 12; j++)
        begin
            rv = $random(seed);
            cv = (j == 0) ? eru_pkg::IDX_UNLOCK - 8'h01 :
                 (j == 1) ? eru_pkg::IDX_GRP_LAST + 8'h01 : {3'h1, rv[4:0]};
            @(negedge core_clk);
            crtc_index = cv;
            #1;
            hit_ex = (cv >= eru_pkg::IDX_UNLOCK) && (cv <= eru_pkg::IDX_GRP_LAST);
            `CHK("reg hit", hit_ex, reg_hit)
        end
        tend("reset");
        wr(eru_pkg::IDX_UNLOCK, 8'h85);
        rdchk(eru_pkg::IDX_UNLOCK, 8'h85, "unlock");
        rv = $random(seed);
        nib = rv[3:0];
        wr(eru_pkg::IDX_CFG_SW, exp_cfg(nib));
        rdchk(eru_pkg::IDX_CFG_SW, exp_cfg(nib), "cfg");
        `CHK("ega emu", nib[3], ega_emu)
        cv = exp_cfg(4'h0);
        ega_compat = 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            misc_out_sel = s[1:0];
            #1;
            `CHK("strap bit", cv[7 - s], misc_in_strap)
            @(negedge core_clk);
        end
        ega_compat = 1'b0;
        #1;
        `CHK("strap off", 1'b0, misc_in_strap)
        tend("config");
        rv = $random(seed);
        sv = rv[7:0];
        wr(eru_pkg::IDX_SCRATCH, sv);
        rdchk(eru_pkg::IDX_SCRATCH, sv, "scratch");
        `CHK("lp off", 1'b0, lp_adj_valid)
        misc3_lp_en = 1'b1;
        #1;
        `CHK("lp on", {1'b1, sv}, {lp_adj_valid, lp_adj})
        // A write while the clock enable is low must not land
        ce = 1'b0;
        wr(eru_pkg::IDX_SCRATCH, ~sv);
        ce = 1'b1;
        rdchk(eru_pkg::IDX_SCRATCH, sv, "ce hold");
        tend("scratch");
        rv = $random(seed);
        hs = rv[7:0];
        wr(eru_pkg::IDX_HALF_ST, hs);
        for (int k = 0; k < 8; k++)
        begin
            rv = $random(seed);
            ctl = {k[2:0], rv[4:0]};
            wr(eru_pkg::IDX_HALF_END, ctl);
            vsync_pos = rv[5];
            #1;
            `CHK("ctl", {ctl[7], ctl[6] & rv[5], ctl[5:0]}, {crtc_irq_en, dbl_scan, interlace_en, half_end})
            `CHK("half start", ctl[5] ? hs : 8'h00, half_start)
            rdchk(eru_pkg::IDX_HALF_END, ctl, "ctl rd");
        end
        tend("interlace");
        for (int c = 0; c < 8; c++)
        begin
            wr(eru_pkg::IDX_UNLOCK, {5'h10, c[2:0]});
            rv = $random(seed);
            wr(eru_pkg::IDX_SCRATCH, rv[7:0]);
            if (c == 5)
                sv = rv[7:0];
            rdchk(eru_pkg::IDX_SCRATCH, sv, "wprot");
        end
        for (int m = 0; m < 4; m++)
        begin
            wr(eru_pkg::IDX_UNLOCK, {m[1], 3'h0, m[0], 3'h5});
            rdchk(eru_pkg::IDX_SCRATCH, (m == 2) ? sv : 8'h00, "rprot");
        end
        wr(eru_pkg::IDX_UNLOCK, 8'hd5);
        `CHK("test mode", 1'b1, test_mode)
        rdchk(eru_pkg::IDX_UNLOCK, 8'hd5, "pad");
        wr(eru_pkg::IDX_UNLOCK, 8'ha5);
        `CHK("test mode", 1'b0, test_mode)
        tend("protect");
        for (int i = 0; i < 4; i++)
        begin
            lk = (i == 3) ? 4'h4 : i[3:0];
            wr(eru_pkg::IDX_CFG_SW, cv);
            rv = $random(seed);
            d0 = rv[5:0];
            d1 = ~d0;
            oth(d0, 1'b1);
            wr(eru_pkg::IDX_CFG_SW, {cv[7:4], lk});
            oth(d1, ~lk[2]);
            `CHK("clk sel", lk[2] ? d0[1:0] : d1[1:0], clk_sel_eff_q)
            `CHK("gc05", lk[1] ? d0[1:0] : d1[1:0], gc05_eff_q)
            `CHK("sq03", lk[1] ? d0 : d1, sq03_eff_q)
            `CHK("sq01", {lk[1] ? d0[4:1] : d1[4:1], lk[0] ? d0[0] : d1[0]}, sq01_eff_q)
        end
        tend("locks");
        // Hard reset keeps scratch and the low interlace field
        for (int m = 0; m < 3; m++)
        begin
            do_reset(m[0], m[1]);
            `CHK("host", exp_host(m[0], m[1]), host_mode)
            `CHK("ilace kept", {3'h0, ctl[4:0]}, {crtc_irq_en, dbl_scan, interlace_en, half_end})
            rdchk(eru_pkg::IDX_UNLOCK, 8'h00, "unlock");
        end
        wr(eru_pkg::IDX_UNLOCK, 8'h85);
        rdchk(eru_pkg::IDX_CFG_SW, exp_cfg(4'h0), "cfg");
        rdchk(eru_pkg::IDX_SCRATCH, sv, "scratch");
        tend("rereset");
        end_sim();
    end

    // Generous ceiling: the sequence needs well under 2000 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            end_sim();
        end
    end
endmodule : tb_ext_reg_unlock_and_interlace_ctrl
